// ### src/wds_pkg.sv
package wds_pkg;
   // Register addresses on the plain register port
   localparam logic [15:0] ADDR_CONFIG = 16'h2007;
   localparam logic [15:0] ADDR_OPTION_LO = 16'h0081;
   localparam logic [15:0] ADDR_OPTION_HI = 16'h0181;
   localparam logic [15:0] ADDR_STATUS = 16'h0003;
   localparam logic [15:0] ADDR_IRQ_CTRL = 16'h000b;
   // Field positions
   localparam int CFG_WDT_EN_BIT = 2;
   localparam int OPT_ASSIGN_BIT = 3;
   localparam int OPT_SEL_LSB = 0;
   localparam int STAT_PD_BIT = 3;
   localparam int STAT_TO_BIT = 4;
   localparam int IRQ_GIE_BIT = 7;
   // Reset values
   localparam logic [7:0] CONFIG_RESET = 8'hff;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic GIE_RESET = 1'b0;
   // Interrupt vector address
   localparam logic [15:0] IRQ_VECTOR = 16'h0004;
   // Widths of the counters and the wake source set
   localparam int WDT_BITS = 8;
   localparam int POST_BITS = 7;
   localparam int WAKE_SRCS = 12;
   // Timing counts
   localparam int SYNC_STAGES = 3;

   // Sleep state, Gray coded along awake, asleep, resume
   typedef enum logic [1:0] {
      WDS_AWAKE = 2'b00,
      WDS_ASLEEP = 2'b01,
      WDS_RESUME = 2'b11
   } wds_state_type;

   // Instruction events from the core, one-cycle pulses
   typedef struct packed {
      logic clear_watchdog_instr;
      logic sleep_instr;
      logic instr_done;
   } wds_core_req_type;

   // Answers to the core
   typedef struct packed {
      logic device_reset;
      logic watchdog_reset;
      logic wake;
      logic prefetch;
      logic vector_load;
      logic push_return;
      logic [15:0] vector_addr;
   } wds_core_rsp_type;

   // Register port request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wds_reg_req_type;
endpackage

// ### src/wds_watchdog_sleep.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module wds_watchdog_sleep (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_wdt_osc,
   input wire logic i_master_clear_pin_n,
   input wire wds_pkg::wds_reg_req_type i_reg,
   output logic [7:0] o_rdata,
   input wire wds_pkg::wds_core_req_type i_core,
   output wds_pkg::wds_core_rsp_type o_core,
   input wire logic [wds_pkg::WAKE_SRCS-1:0] i_irq_flags,
   input wire logic [wds_pkg::WAKE_SRCS-1:0] i_irq_enables,
   output logic o_osc_off,
   output logic o_hold_io
);
   import wds_pkg::*;

   // Reset synchroniser
   logic rst_s1;
   logic rst_n;
   // Pin synchronisers, three stages each
   logic [SYNC_STAGES-1:0] osc_sync;
   logic [SYNC_STAGES-1:0] master_clear_pin_sync;
   logic osc_lvl; // Filtered oscillator level
   logic master_clear_pin_lvl; // Filtered master clear level, low means reset
   // Registers
   logic [7:0] config_word; // Device configuration word
   logic [7:0] option_ctrl; // Option control
   logic timeout_flag;
   logic powerdown_flag;
   logic global_irq_enable;
   // Watchdog counters
   logic [WDT_BITS-1:0] wdt_cnt;
   logic [POST_BITS-1:0] post_cnt;
   wds_state_type state;
   wds_state_type next_state;
   // Answer flip-flops
   logic device_reset;
   logic watchdog_reset;
   logic wake;
   logic prefetch;
   logic vector_load;
   logic [7:0] rdata;

   // Asynchronous assert, clocked release
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // Pin sampling; first stage only feeds the second
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_sync <= '0;
         master_clear_pin_sync <= '1;
         osc_lvl <= 1'b0;
         master_clear_pin_lvl <= 1'b1;
      end else begin
         osc_sync <= {osc_sync[SYNC_STAGES-2:0], i_wdt_osc};
         master_clear_pin_sync <= {master_clear_pin_sync[SYNC_STAGES-2:0], i_master_clear_pin_n};
         // Level changes only when stages two and three agree
         if (osc_sync[1] == osc_sync[2]) begin
            osc_lvl <= osc_sync[2];
         end
         if (master_clear_pin_sync[1] == master_clear_pin_sync[2]) begin
            master_clear_pin_lvl <= master_clear_pin_sync[2];
         end
      end
   end

   // Decoding and selection
   wire osc_edge = osc_sync[1] & osc_sync[2] & ~osc_lvl;
   wire master_clear_pin_fall = ~master_clear_pin_sync[1] & ~master_clear_pin_sync[2] & master_clear_pin_lvl;
   wire wdt_enabled = config_word[CFG_WDT_EN_BIT];
   wire post_to_wdt = option_ctrl[OPT_ASSIGN_BIT];
   wire [2:0] post_sel = option_ctrl[OPT_SEL_LSB +: 3];
   wire [POST_BITS-1:0] post_last = POST_BITS'((8'h01 << post_sel) - 8'h01);
   wire wdt_wrap = osc_edge & (&wdt_cnt);
   wire post_done = post_to_wdt ? (post_cnt == post_last) : 1'b1;
   wire time_out = wdt_enabled & wdt_wrap & post_done;
   wire [WAKE_SRCS-1:0] irq_armed = i_irq_flags & i_irq_enables;
   wire irq_pending = |irq_armed;
   wire is_awake = (state == WDS_AWAKE);
   wire is_asleep = (state == WDS_ASLEEP);
   wire sleep_go = is_awake & i_core.sleep_instr & ~irq_pending;
   wire sleep_nop = is_awake & i_core.sleep_instr & irq_pending;
   wire wdt_clear = (is_awake & i_core.clear_watchdog_instr) | sleep_go;
   wire wake_irq = is_asleep & irq_pending;
   wire wake_wdt = is_asleep & time_out;
   wire reset_wdt = is_awake & time_out & ~wdt_clear;
   wire reset_master_clear_pin = master_clear_pin_fall;
   wire take_vector = (state == WDS_RESUME) & i_core.instr_done & global_irq_enable;
   wire wr_option = i_reg.wr & ((i_reg.addr == ADDR_OPTION_LO) | (i_reg.addr == ADDR_OPTION_HI));
   wire wr_config = i_reg.wr & (i_reg.addr == ADDR_CONFIG);
   wire wr_irq = i_reg.wr & (i_reg.addr == ADDR_IRQ_CTRL);
   // Flags widened to a byte before they are shifted into place
   wire [7:0] status_view = (8'(timeout_flag) << STAT_TO_BIT) | (8'(powerdown_flag) << STAT_PD_BIT);
   wire [7:0] irq_view = 8'(global_irq_enable) << IRQ_GIE_BIT;
   wire [7:0] read_mux;

   // Read selection; unmapped addresses read zero
   assign read_mux = (i_reg.addr == ADDR_CONFIG) ? config_word :
                     ((i_reg.addr == ADDR_OPTION_LO) | (i_reg.addr == ADDR_OPTION_HI)) ?
                     option_ctrl :
                     (i_reg.addr == ADDR_STATUS) ? status_view :
                     (i_reg.addr == ADDR_IRQ_CTRL) ? irq_view : 8'h00;

   // Next state of the sleep sequencer
   always_comb begin
      next_state = state;
      case (state)
         WDS_AWAKE: begin
            if (sleep_go) begin
               next_state = WDS_ASLEEP;
            end
         end
         WDS_ASLEEP: begin
            if (reset_master_clear_pin) begin
               next_state = WDS_AWAKE;
            end else if (wake_irq) begin
               next_state = WDS_RESUME;
            end else if (wake_wdt) begin
               next_state = WDS_RESUME;
            end
         end
         WDS_RESUME: begin
            // Wait for the prefetched instruction to retire
            if (i_core.instr_done | reset_master_clear_pin) begin
               next_state = WDS_AWAKE;
            end
         end
         default: begin
            next_state = WDS_AWAKE;
         end
      endcase
   end

   // Sequencer state
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= WDS_AWAKE;
      end else begin
         state <= next_state;
      end
   end

   // Watchdog counter and postscaler on oscillator ticks
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_cnt <= '0;
         post_cnt <= '0;
      end else if (wdt_clear | ~wdt_enabled | time_out) begin
         wdt_cnt <= '0;
         post_cnt <= '0;
      end else if (osc_edge) begin
         wdt_cnt <= wdt_cnt + 1'b1;
         if (wdt_wrap & post_to_wdt) begin
            post_cnt <= post_cnt + 1'b1;
         end
      end
   end

   // Software registers; the assignment bit moves only by a write
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         config_word <= CONFIG_RESET;
         option_ctrl <= OPTION_RESET;
      end else begin
         if (wr_config) begin
            config_word <= i_reg.wdata;
         end
         if (wr_option) begin
            option_ctrl <= i_reg.wdata;
         end
      end
   end

   // Global interrupt enable; servicing clears it
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         global_irq_enable <= GIE_RESET;
      end else if (take_vector) begin
         global_irq_enable <= 1'b0;
      end else if (wr_irq) begin
         global_irq_enable <= i_reg.wdata[IRQ_GIE_BIT];
      end
   end

   // Status flags; set at power-up
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         timeout_flag <= 1'b1;
         powerdown_flag <= 1'b1;
      end else begin
         if (time_out & ~wdt_clear) begin
            timeout_flag <= 1'b0;
         end else if (sleep_go) begin
            timeout_flag <= 1'b1;
         end else if (is_awake & i_core.clear_watchdog_instr) begin
            timeout_flag <= 1'b1;
         end
         if (sleep_go) begin
            powerdown_flag <= 1'b0;
         end else if (is_awake & i_core.clear_watchdog_instr) begin
            powerdown_flag <= 1'b1;
         end
      end
   end

   // Answer pulses to the core
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         device_reset <= 1'b0;
         watchdog_reset <= 1'b0;
         wake <= 1'b0;
         prefetch <= 1'b0;
         vector_load <= 1'b0;
      end else begin
         device_reset <= reset_wdt | reset_master_clear_pin;
         watchdog_reset <= reset_wdt;
         wake <= (wake_irq | wake_wdt) & ~reset_master_clear_pin;
         prefetch <= sleep_go | sleep_nop;
         vector_load <= take_vector;
      end
   end

   // Registered read data, valid the cycle after the strobe
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (i_reg.rd) begin
         rdata <= read_mux;
      end else begin
         rdata <= 8'h00;
      end
   end

   // Output assembly
   assign o_rdata = rdata;
   assign o_core.device_reset = device_reset;
   assign o_core.watchdog_reset = watchdog_reset;
   assign o_core.wake = wake;
   assign o_core.prefetch = prefetch;
   assign o_core.vector_load = vector_load;
   assign o_core.push_return = vector_load;
   assign o_core.vector_addr = IRQ_VECTOR;
   assign o_osc_off = is_asleep;
   assign o_hold_io = is_asleep;
endmodule // wds_watchdog_sleep

// ### sim/wds_core_model.sv
`timescale 1ns/100ps
// Processor core stand-in: issues clear and sleep, retires prefetched word
module wds_core_model (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_do_clear,
   input wire logic i_do_sleep,
   input wire wds_pkg::wds_core_rsp_type i_rsp,
   output wds_pkg::wds_core_req_type o_req
);
   import wds_pkg::*;
   logic sleep_due; // Sleep one cycle after its clear
   logic [1:0] done_wait; // Cycles left before retiring after wake
   // Instruction pulses, one cycle each
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_req <= '0;
         sleep_due <= 1'b0;
         done_wait <= 2'h0;
      end else begin
         o_req.clear_watchdog_instr <= i_do_clear | i_do_sleep;
         sleep_due <= i_do_sleep;
         o_req.sleep_instr <= sleep_due;
         done_wait <= i_rsp.wake ? 2'h2 : done_wait - (done_wait != 2'h0);
         o_req.instr_done <= done_wait == 2'h1;
      end
   end
endmodule // wds_core_model

// ### sim/wds_watchdog_sleep_monitor.sv
`timescale 1ns/100ps
module wds_watchdog_sleep_monitor (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_master_clear_pin_n,
   input wire wds_pkg::wds_reg_req_type i_reg,
   input wire logic [7:0] o_rdata,
   input wire wds_pkg::wds_core_req_type i_core,
   input wire wds_pkg::wds_core_rsp_type o_core,
   input wire logic [wds_pkg::WAKE_SRCS-1:0] i_irq_flags,
   input wire logic [wds_pkg::WAKE_SRCS-1:0] i_irq_enables,
   input wire logic o_osc_off,
   input wire logic o_hold_io
);
   import wds_pkg::*;
   wire pend = |(i_irq_flags & i_irq_enables); // Enabled source waiting
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // Sleep taken while awake; asleep with a live source
   sequence s_sleep; i_core.sleep_instr && !o_osc_off; endsequence
   sequence s_irq_asleep; o_osc_off && pend; endsequence
   property p_prefetch; s_sleep |=> o_core.prefetch; endproperty
   property p_enter; s_sleep ##0 !pend |=> o_osc_off; endproperty
   property p_noop; s_sleep ##0 pend |=> (!o_osc_off) [*2]; endproperty
   property p_wake; s_irq_asleep |=> o_core.wake && !o_osc_off; endproperty
   property p_hold; o_hold_io == o_osc_off; endproperty
   property p_vector;
      o_core.vector_load |-> o_core.push_return && o_core.vector_addr == IRQ_VECTOR;
   endproperty
   property p_wdrst;
      o_core.watchdog_reset |-> o_core.device_reset && !$past(o_osc_off);
   endproperty
   property p_master_clear_pin; $fell(i_master_clear_pin_n) |-> ##[1:8] o_core.device_reset; endproperty
   property p_status;
      i_reg.rd && i_reg.addr == ADDR_STATUS |=> o_rdata[7:5] == 3'h0 && o_rdata[2:0] == 3'h0;
   endproperty
   a_prefetch: assert property (p_prefetch) else $error("no prefetch");
   a_enter: assert property (p_enter) else $error("sleep not entered");
   a_noop: assert property (p_noop) else $error("pending sleep not a no-op");
   a_wake: assert property (p_wake) else $error("no wake on source");
   a_hold: assert property (p_hold) else $error("pin hold mismatch");
   a_vector: assert property (p_vector) else $error("bad vector load");
   a_wdrst: assert property (p_wdrst) else $error("bad watchdog reset");
   a_master_clear_pin: assert property (p_master_clear_pin) else $error("no master clear reset");
   a_status: assert property (p_status) else $error("status spare bits set");
endmodule // wds_watchdog_sleep_monitor
bind wds_watchdog_sleep wds_watchdog_sleep_monitor mon (
   .i_clk, .i_nrst, .i_master_clear_pin_n, .i_reg, .o_rdata, .i_core, .o_core,
   .i_irq_flags, .i_irq_enables, .o_osc_off, .o_hold_io
);

// ### sim/wds_watchdog_sleep_bench.sv
`timescale 1ns/100ps
module wds_watchdog_sleep_bench;
   import wds_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic osc = 1'b0;
   logic master_clear_pin_n = 1'b1;
   logic do_clear = 1'b0;
   logic do_sleep = 1'b0;
   logic hit;
   logic osc_off;
   logic hold_io;
   logic [7:0] rdata;
   logic [7:0] d;
   logic [WAKE_SRCS-1:0] flags = '0;
   logic [WAKE_SRCS-1:0] ens = '0;
   wds_reg_req_type req = '0;
   wds_core_req_type core_req;
   wds_core_rsp_type core_rsp;
   int fails = 0;
   int samples_checked = 0;
   int waited;
   int cyc = 0;
   always #12.5 clk = ~clk;
   // Watchdog oscillator, 200 ns, never on a clock edge
   initial begin
      #7;
      forever #100 osc = ~osc;
   end
   wds_watchdog_sleep uut (
      .i_clk(clk), .i_nrst(nrst), .i_wdt_osc(osc), .i_master_clear_pin_n(master_clear_pin_n),
      .i_reg(req), .o_rdata(rdata), .i_core(core_req), .o_core(core_rsp),
      .i_irq_flags(flags), .i_irq_enables(ens), .o_osc_off(osc_off), .o_hold_io(hold_io));
   wds_core_model core (.i_clk(clk), .i_nrst(nrst), .i_do_clear(do_clear),
      .i_do_sleep(do_sleep), .i_rsp(core_rsp), .o_req(core_req));
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails = fails + 1;
         report_and_stop();
      end
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic cmd(input logic slp);
      @(posedge clk);
      do_sleep <= slp;
      do_clear <= !slp;
      @(posedge clk);
      do_sleep <= 1'b0;
      do_clear <= 1'b0;
   endtask
   // Bounded wait: 0 wake, 1 reset, 2 vector, 3 asleep
   task automatic wait_rsp(input int sel, input int lim);
      logic [3:0] v;
      hit = 1'b0;
      for (waited = 0; waited < lim && hit !== 1'b1; waited++) begin
         @(posedge clk);
         #1;
         v = {osc_off, core_rsp.vector_load, core_rsp.device_reset, core_rsp.wake};
         hit = v[sel];
      end
   endtask
   task automatic t_regs;
      rd(ADDR_CONFIG);
      cmp(d, CONFIG_RESET);
      rd(ADDR_OPTION_LO);
      cmp(d, OPTION_RESET);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS);
      cmp(d, 8'h18);
      rd(ADDR_IRQ_CTRL);
      cmp(d[7], GIE_RESET);
      rd(16'h0055);
      cmp(d, 8'h00);
      wr(ADDR_OPTION_HI, 8'h09);
      rd(ADDR_OPTION_LO);
      cmp(d, 8'h09);
   endtask
   // Awake time-out at 1:2, timed from a clear
   task automatic t_wdt_reset;
      cmd(1'b0);
      wait_rsp(1, 6000);
      cmp(core_rsp.watchdog_reset, 1'b1);
      cmp(waited >= 4080 && waited <= 4120, 1'b1);
      rd(ADDR_STATUS);
      cmp(d, 8'h08);
   endtask
   task automatic t_sleep_noop;
      wr(ADDR_OPTION_LO, 8'h00);
      @(posedge clk);
      flags <= 12'h008;
      ens <= 12'h008;
      cmd(1'b1);
      wait_rsp(3, 8);
      cmp(hit, 1'b0);
      rd(ADDR_STATUS);
      cmp(d, 8'h18);
   endtask
   task automatic t_sleep_irq;
      wr(ADDR_IRQ_CTRL, 8'h80);
      @(posedge clk);
      flags <= 12'h040;
      ens <= 12'h000;
      cmd(1'b1);
      wait_rsp(3, 8);
      cmp(hold_io, 1'b1);
      rd(ADDR_STATUS);
      cmp(d, 8'h10);
      wait_rsp(0, 10);
      cmp(hit, 1'b0);
      @(posedge clk);
      ens <= 12'h040;
      wait_rsp(0, 4);
      cmp(hit, 1'b1);
      wait_rsp(2, 8);
      cmp(hit, 1'b1);
      rd(ADDR_IRQ_CTRL);
      cmp(d[7], 1'b0);
      @(posedge clk);
      flags <= '0;
   endtask
   task automatic t_wdt_wake;
      cmd(1'b1);
      wait_rsp(0, 2600);
      cmp(hit, 1'b1);
      cmp(core_rsp.device_reset, 1'b0);
      wait_rsp(2, 8);
      cmp(hit, 1'b0);
      rd(ADDR_STATUS);
      cmp(d, 8'h00);
   endtask
   task automatic t_fuse_master_clear_pin;
      wr(ADDR_CONFIG, 8'hfb);
      cmd(1'b0);
      wait_rsp(1, 3000);
      cmp(hit, 1'b0);
      wr(ADDR_CONFIG, 8'hff);
      cmd(1'b1);
      wait_rsp(3, 8);
      @(posedge clk);
      master_clear_pin_n <= 1'b0;
      wait_rsp(1, 10);
      cmp(hit, 1'b1);
      cmp(osc_off, 1'b0);
      @(posedge clk);
      master_clear_pin_n <= 1'b1;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_wdt_reset();
      t_sleep_noop();
      t_sleep_irq();
      t_wdt_wake();
      t_fuse_master_clear_pin();
      report_and_stop();
   end
endmodule // wds_watchdog_sleep_bench
